// [hw/bss_map.svh]
// Constants for the bias sweep sequencer: limits, indices and timing.
// Assumes inclusion by bare name from the sequencer design files.
`ifndef BSS_MAP_SVH
`define BSS_MAP_SVH

`define BSS_P_STARTT 3'h0
`define BSS_P_STOPT 3'h1
`define BSS_P_STEPT 3'h2
`define BSS_P_FIRST 3'h3
`define BSS_P_LAST 3'h4
`define BSS_P_STEPV 3'h5
`define BSS_P_DEFV 3'h6
`define BSS_P_COUNT 3'h7

`define BSS_MASK_DC 8'hCD
`define BSS_MASK_EXT 8'h85
`define BSS_MASK_RAMP 8'h7F
`define BSS_WAVE_LAST 3'h4

`define BSS_TIME_MIN 16'h0001
`define BSS_TIME_MAX 16'hFDE8
`define BSS_V_MIN (-17'sh04E20)
`define BSS_V_MAX 17'sh04E20
`define BSS_CNT_MIN 16'h0001
`define BSS_CNT_MAX 11'h1C2
`define BSS_CNT_FAST 11'h546
`define BSS_QSTEP 16'sh0005

`define BSS_RST_TIME 16'h0001
`define BSS_RST_V 16'h0000
`define BSS_RST_CNT 16'h0001

`define BSS_CLK_NS 40
`define BSS_TICK_NS 1024000
`define BSS_TMR_LAST 16'h0001

`endif

// [hw/bss_pkg.sv]
// Types shared by the bias sweep sequencer modules.
// Assumes nothing beyond a SystemVerilog compiler.
package bss_pkg;

	typedef enum logic [2:0] {
		wv_dc = 3'h0,
		wv_stair = 3'h1,
		dual_ramp_choice = 3'h2,
		wv_pulse = 3'h3,
		outside_source_choice = 3'h4
	} bss_wave_e;

	typedef enum logic [2:0] {
		st_idle = 3'h0,
		st_start = 3'h1,
		st_settle = 3'h3,
		st_meas = 3'h2,
		st_stoph = 3'h6,
		st_gap = 3'h7
	} bss_state_e;

	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} bss_tick_s;

	typedef struct packed {
		logic bias_on;
		logic trig_seen;
		logic ext_sel;
		bss_wave_e wave;
		bss_wave_e wave_p;
		logic [7:0][15:0] act;
		logic [7:0][15:0] shd;
		logic [2:0] sel;
		bss_state_e st;
		logic [15:0] tmr;
		logic [15:0] lvl;
		logic down;
		logic [10:0] idx;
		logic [10:0] total;
		logic err_inv;
		logic err_conf;
		logic buf_we;
		logic buf_clr;
		logic meas_go;
		logic sweep;
		logic ext_msg;
		logic [10:0] addr;
		logic [15:0] bias;
	} bss_main_s;

endpackage

// [hw/bss_quant.sv]
// Bias quantiser: snaps a millivolt setting onto the output stage grid.
// Assumes a signed millivolt input within the accepted bias range.
`timescale 1ns/1ns
`default_nettype none
`include "bss_map.svh"

module bss_quant
	import bss_pkg::*;
(
	// Setting in and applied value out
	input wire logic [15:0] mv,
	output logic [15:0] q
);

	// Signed division truncates toward zero, which is what the grid asks.
	assign q = 16'(($signed(mv) / `BSS_QSTEP) * `BSS_QSTEP);

endmodule
`default_nettype wire

// [hw/bss_seq.sv]
// Bias sweep sequencer: parameter store, keypad editing and sweep control.
// Assumes one clock, synchronous keypad pulses and a measurement unit
// that answers each measurement start with a done pulse.
`timescale 1ns/1ns
`default_nettype none
`include "bss_map.svh"

module bss_seq
	import bss_pkg::*;
#(
	parameter int unsigned TICK_CYC = `BSS_TICK_NS / `BSS_CLK_NS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Keypad commands
	input wire logic wave_pick_valid,
	input wire logic [2:0] wave_pick,
	input wire logic param_next,
	input wire logic param_prev,
	input wire logic edit_valid,
	input wire logic [15:0] edit_value,
	input wire logic commit,
	input wire logic cancel,
	input wire logic bias_key,
	// Measurement side
	input wire logic trigger,
	input wire logic fast_rate,
	input wire logic meas_done,
	// Output stage
	output logic bias_on,
	output logic bias_ind,
	output logic ext_select,
	output logic [15:0] bias_mv,
	// Reading buffer and measurement
	output logic meas_start,
	output logic buf_we,
	output logic [10:0] buf_addr,
	output logic buf_clear,
	output logic sweep_active,
	output logic [10:0] reading_total,
	// Operator display
	output logic [2:0] param_shown,
	output logic err_invalid,
	output logic err_conflict,
	output logic outside_source_idle_message
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	function automatic logic applies(bss_wave_e w, logic [2:0] p);
		logic [7:0] m;
		unique case (w)
			wv_dc: m = `BSS_MASK_DC;
			outside_source_choice: m = `BSS_MASK_EXT;
			wv_stair, dual_ramp_choice, wv_pulse: m = `BSS_MASK_RAMP;
			default: m = `BSS_MASK_RAMP;
		endcase
		return m[p];
	endfunction

	function automatic logic [2:0] seek(bss_wave_e w, logic [2:0] cur,
		logic up);
		logic [2:0] p;
		logic [2:0] r;
		logic hit;
		p = cur;
		r = cur;
		hit = 1'b0;
		for (int i = 0; i < 8; i++) begin
			p = up ? p + 3'h1 : p - 3'h1;
			if (!hit && applies(w, p)) begin
				r = p;
				hit = 1'b1;
			end
		end
		return r;
	endfunction

	function automatic logic in_range(logic [2:0] p, logic [15:0] v,
		logic fast);
		logic [15:0] top;
		top = {5'h00, fast ? `BSS_CNT_FAST : `BSS_CNT_MAX};
		if (p == `BSS_P_COUNT) begin
			return v >= `BSS_CNT_MIN && v <= top;
		end else if (p <= `BSS_P_STEPT) begin
			return v >= `BSS_TIME_MIN && v <= `BSS_TIME_MAX;
		end
		// The bottom of the range is inclusive of -20.000 V.
		return $signed({v[15], v}) >= `BSS_V_MIN &&
			$signed({v[15], v}) <= `BSS_V_MAX;
	endfunction

	// Returns the conflict flag above an 11-bit reading count.
	function automatic logic [11:0] calc_total(bss_wave_e w,
		logic [15:0] f, logic [15:0] l, logic [15:0] st, logic [15:0] c);
		logic signed [16:0] d;
		logic signed [16:0] dv;
		logic signed [16:0] q;
		logic signed [16:0] r;
		logic signed [17:0] nn;
		logic bad;
		d = $signed({l[15], l}) - $signed({f[15], f});
		dv = (st == 16'h0000) ? 17'sh00001 : $signed({st[15], st});
		q = d / dv;
		r = d % dv;
		bad = (st == 16'h0000) || (d > 0 && st[15]) ||
			(d < 0 && !st[15]);
		nn = 18'(q) + 18'sh00001 + ((r != 0) ? 18'sh00001 : 18'sh00000);
		if (w == dual_ramp_choice) begin
			nn = nn + nn - 18'sh00001;
		end
		if (w == wv_dc || w == outside_source_choice) begin
			return {1'b0, c[10:0]};
		end
		if (bad || nn > 18'(`BSS_CNT_MAX)) begin
			return {1'b1, `BSS_CNT_MAX};
		end
		return {1'b0, nn[10:0]};
	endfunction

	// Moves one step toward the target and stops on it exactly.
	function automatic logic [15:0] step_to(logic [15:0] lv,
		logic [15:0] st, logic [15:0] tg);
		logic signed [16:0] nx;
		logic signed [16:0] t;
		nx = $signed({lv[15], lv}) + $signed({st[15], st});
		t = $signed({tg[15], tg});
		if ((!st[15] && nx >= t) || (st[15] && nx <= t)) begin
			return tg;
		end
		return nx[15:0];
	endfunction

	// ----------------------------------------------------------------
	// State and helpers
	// ----------------------------------------------------------------

	// Three times, four voltages and the count, index zero last.
	localparam logic [7:0][15:0] RST_PAR = {`BSS_RST_CNT, `BSS_RST_V,
		`BSS_RST_V, `BSS_RST_V, `BSS_RST_V, `BSS_RST_TIME, `BSS_RST_TIME,
		`BSS_RST_TIME};

	bss_main_s s;
	bss_main_s n;
	logic tick;
	logic tick_rst;
	logic done;
	logic [11:0] tot;
	logic [15:0] neg_step;
	logic [15:0] bias_src;
	logic [15:0] qv;
	logic [10:0] lim;

	assign tot = calc_total(s.wave_p, s.shd[`BSS_P_FIRST],
		s.shd[`BSS_P_LAST], s.shd[`BSS_P_STEPV], s.shd[`BSS_P_COUNT]);
	assign neg_step = 16'h0000 - s.act[`BSS_P_STEPV];
	assign lim = fast_rate ? `BSS_CNT_FAST : `BSS_CNT_MAX;
	// Default level whenever no sweep step is being held.
	assign bias_src = (s.st == st_idle || s.st == st_gap) ?
		s.act[`BSS_P_DEFV] : s.lvl;

	bss_quant u_quant (
		.mv(bias_src),
		.q(qv)
	);

	bss_tick #(
		.TICK_CYC(TICK_CYC)
	) u_tick (
		.clk(clk),
		.rstn(rstn),
		.restart(tick_rst),
		.tick(tick)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------

	always_comb begin
		n = s;
		tick_rst = 1'b0;
		done = tick && (s.tmr == `BSS_TMR_LAST);
		n.err_inv = 1'b0;
		n.err_conf = 1'b0;
		n.buf_we = 1'b0;
		n.buf_clr = 1'b0;
		n.meas_go = 1'b0;
		n.bias = qv;

		// Editing works on the shadow copy only.
		if (wave_pick_valid) begin
			if (wave_pick <= `BSS_WAVE_LAST) begin
				n.wave_p = bss_wave_e'(wave_pick);
				n.sel = seek(n.wave_p, `BSS_P_COUNT, 1'b1);
			end else begin
				n.err_inv = 1'b1;
			end
		end else if (param_next || param_prev) begin
			n.sel = seek(s.wave_p, s.sel, param_next);
		end else if (edit_valid) begin
			if (applies(s.wave_p, s.sel) &&
				in_range(s.sel, edit_value, fast_rate)) begin
				n.shd[s.sel] = edit_value;
			end else begin
				n.err_inv = 1'b1;
			end
		end
		if (commit) begin
			n.act = s.shd;
			n.wave = s.wave_p;
			n.ext_sel = (s.wave_p == outside_source_choice);
			n.total = tot[10:0];
			n.err_conf = tot[11];
		end else if (cancel) begin
			n.shd = s.act;
			n.wave_p = s.wave;
		end

		if (tick && s.tmr != 16'h0000) begin
			n.tmr = s.tmr - 16'h0001;
		end

		unique case (s.st)
			st_idle: begin
				if (trigger && s.bias_on) begin
					n.st = st_start;
					n.tmr = s.act[`BSS_P_STARTT];
					tick_rst = 1'b1;
					n.trig_seen = 1'b1;
					n.idx = 11'h000;
					n.lvl = s.act[`BSS_P_FIRST];
					n.down = 1'b0;
				end
			end
			st_start: begin
				if (done) begin
					n.st = st_settle;
					n.tmr = s.act[`BSS_P_STEPT];
					tick_rst = 1'b1;
				end
			end
			st_settle: begin
				if (done) begin
					n.st = st_meas;
					n.meas_go = 1'b1;
				end
			end
			st_meas: begin
				if (meas_done) begin
					n.buf_we = (s.idx < lim);
					n.addr = s.idx;
					if (s.idx + 11'h001 >= s.total) begin
						n.st = st_stoph;
						n.tmr = s.act[`BSS_P_STOPT];
					end else begin
						n.idx = s.idx + 11'h001;
						if (s.wave == wv_pulse) begin
							n.st = st_gap;
							n.tmr = s.act[`BSS_P_STOPT];
						end else begin
							n.st = st_settle;
							n.tmr = s.act[`BSS_P_STEPT];
						end
					end
					tick_rst = 1'b1;
					if (s.wave == dual_ramp_choice &&
						(s.down || s.lvl == s.act[`BSS_P_LAST])) begin
						n.down = 1'b1;
						n.lvl = step_to(s.lvl, neg_step,
							s.act[`BSS_P_FIRST]);
					end else if (s.wave != wv_dc &&
						s.wave != outside_source_choice) begin
						n.lvl = step_to(s.lvl, s.act[`BSS_P_STEPV],
							s.act[`BSS_P_LAST]);
					end
				end
			end
			st_gap: begin
				if (done) begin
					n.st = st_settle;
					n.tmr = s.act[`BSS_P_STEPT];
					tick_rst = 1'b1;
				end
			end
			st_stoph: begin
				if (done) begin
					n.st = st_idle;
				end
			end
			default: begin
				n.st = st_idle;
			end
		endcase

		// The bias key wins over any sweep activity in the same cycle.
		if (bias_key) begin
			n.bias_on = !s.bias_on;
			n.st = st_idle;
			n.idx = 11'h000;
			n.buf_clr = 1'b1;
			n.buf_we = 1'b0;
			n.meas_go = 1'b0;
			n.trig_seen = 1'b0;
		end
		n.sweep = (n.st != st_idle);
		n.ext_msg = n.bias_on && n.ext_sel && !n.trig_seen;
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.act <= RST_PAR;
			s.shd <= RST_PAR;
			s.total <= 11'(`BSS_RST_CNT);
		end else begin
			s <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------

	assign bias_on = s.bias_on;
	assign bias_ind = s.bias_on;
	assign ext_select = s.ext_sel;
	assign bias_mv = s.bias;
	assign meas_start = s.meas_go;
	assign buf_we = s.buf_we;
	assign buf_addr = s.addr;
	assign buf_clear = s.buf_clr;
	assign sweep_active = s.sweep;
	assign reading_total = s.total;
	assign param_shown = s.sel;
	assign err_invalid = s.err_inv;
	assign err_conflict = s.err_conf;
	assign outside_source_idle_message = s.ext_msg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);

	property p_toggle;
		bias_key |=> bias_on != $past(bias_on) && bias_ind == bias_on;
	endproperty
	a_toggle: assert property (p_toggle) else $error("no toggle");

	property p_abort;
		bias_key |=> buf_clear && !sweep_active && !buf_we;
	endproperty
	a_abort: assert property (p_abort) else $error("abort missed");

	property p_limit;
		buf_we |-> buf_addr < ($past(fast_rate) ? `BSS_CNT_FAST : `BSS_CNT_MAX);
	endproperty
	a_limit: assert property (p_limit) else $error("buffer over limit");

	property p_total;
		(s.wave != wv_dc && s.wave != outside_source_choice)
			|-> reading_total <= `BSS_CNT_MAX;
	endproperty
	a_total: assert property (p_total) else $error("total above cap");

	property p_quant;
		$signed(bias_mv) % `BSS_QSTEP == 0;
	endproperty
	a_quant: assert property (p_quant) else $error("bias off grid");

	property p_default;
		s.st == st_gap |-> qv == s.act[`BSS_P_DEFV] -
			16'($signed(s.act[`BSS_P_DEFV]) % `BSS_QSTEP)
			##1 bias_mv == $past(qv);
	endproperty
	a_default: assert property (p_default) else $error("gap not default");

	property p_invalid;
		edit_valid && !wave_pick_valid && !param_next && !param_prev &&
			!cancel &&
			!in_range(s.sel, edit_value, fast_rate)
			|=> err_invalid && s.shd[$past(s.sel)] == $past(s.shd[s.sel]);
	endproperty
	a_invalid: assert property (p_invalid) else $error("bad entry kept");

	property p_cancel;
		cancel && !commit |=> s.act == $past(s.act) && s.shd == s.act;
	endproperty
	a_cancel: assert property (p_cancel) else $error("cancel changed");

	property p_measure;
		s.st == st_settle && done && !bias_key |=> meas_start ##1 !meas_start;
	endproperty
	a_measure: assert property (p_measure) else $error("no meas start");

	property p_stop;
		s.st == st_stoph && done && !bias_key |=> !sweep_active
			##1 bias_mv == $past(qv);
	endproperty
	a_stop: assert property (p_stop) else $error("stop hold wrong");

	c_sweep_end: cover property (s.st == st_stoph ##1 s.st == st_idle);
	c_abort: cover property (sweep_active && bias_key);
	c_conflict: cover property (err_conflict);
	c_down: cover property (s.down && s.st == st_meas);

endmodule
`default_nettype wire

// [hw/bss_tick.sv]
// Stretched millisecond tick for the sequencer interval timer.
// Assumes a free running clock; restart realigns the tick phase.
`timescale 1ns/1ns
`default_nettype none
`include "bss_map.svh"

module bss_tick
	import bss_pkg::*;
#(
	parameter int unsigned TICK_CYC = `BSS_TICK_NS / `BSS_CLK_NS
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Control and tick
	input wire logic restart,
	output logic tick
);

	bss_tick_s s;
	bss_tick_s n;

	// One tick per 1.024 ms, so each programmed unit is stretched.
	always_comb begin
		n = s;
		n.tick = 1'b0;
		if (restart) begin
			n.cnt = 16'h0000;
		end else if (s.cnt == 16'(TICK_CYC - 1)) begin
			n.cnt = 16'h0000;
			n.tick = 1'b1;
		end else begin
			n.cnt = s.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
		end else begin
			s <= n;
		end
	end

	assign tick = s.tick;

endmodule
`default_nettype wire

// [testbench/bss_meas_model.sv]
// Measurement unit model that answers each measurement start with done.
// Assumes the sequencer clock; the bench picks the answer latency.
`timescale 1ns/1ns
`default_nettype none

module bss_meas_model (
	// Clock and handshake
	input wire logic clk,
	input wire logic meas_start,
	input wire logic [3:0] lat,
	output logic meas_done
);
	// Done is launched at a falling edge so the sequencer samples it cleanly.
	initial begin
		meas_done = 1'b0;
		forever begin
			@(negedge clk);
			if (meas_start === 1'b1) begin
				repeat (lat) @(negedge clk);
				meas_done = 1'b1;
				@(negedge clk);
				meas_done = 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// [testbench/testbench.sv]
// Self-checking bench for the bias sweep sequencer.
// Assumes the sequencer and the measurement model compile first.
`timescale 1ns/1ns
`default_nettype none

module testbench
	import bss_pkg::*;
;
	logic clk, rstn, wave_pick_valid, param_next, param_prev, edit_valid;
	logic commit, cancel, bias_key, trigger, fast_rate, meas_done;
	logic [2:0] wave_pick, param_shown;
	logic [15:0] edit_value, bias_mv;
	logic bias_on, bias_ind, ext_select, meas_start, buf_we, buf_clear;
	logic sweep_active, err_invalid, err_conflict, idle_msg;
	logic [10:0] buf_addr, reading_total;
	logic [3:0] lat;
	logic [31:0] rs = 32'h000126C8;
	logic [15:0] lvq[$];
	logic [10:0] adq[$];
	int n_fail = 0;
	int checks_done = 0;
	int cyc = 0;
	int i;

	bss_seq #(.TICK_CYC(4)) i_dut (.clk(clk), .rstn(rstn),
		.wave_pick_valid(wave_pick_valid), .wave_pick(wave_pick),
		.param_next(param_next), .param_prev(param_prev),
		.edit_valid(edit_valid), .edit_value(edit_value), .commit(commit),
		.cancel(cancel), .bias_key(bias_key), .trigger(trigger),
		.fast_rate(fast_rate), .meas_done(meas_done), .bias_on(bias_on),
		.bias_ind(bias_ind), .ext_select(ext_select), .bias_mv(bias_mv),
		.meas_start(meas_start), .buf_we(buf_we), .buf_addr(buf_addr),
		.buf_clear(buf_clear), .sweep_active(sweep_active),
		.reading_total(reading_total), .param_shown(param_shown),
		.err_invalid(err_invalid), .err_conflict(err_conflict),
		.outside_source_idle_message(idle_msg));

	bss_meas_model i_meas (.clk(clk), .meas_start(meas_start), .lat(lat),
		.meas_done(meas_done));

	// ----------------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		logic [31:0] y;
		y = x ^ (x << 13);
		y = y ^ (y >> 17);
		return y ^ (y << 5);
	endfunction

	task results();
		if (n_fail == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	task check(input logic [15:0] s, input logic [15:0] e);
		checks_done++;
		if (s !== e) begin
			n_fail++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask

	// Every keypad pulse lasts one full cycle, from falling edge to falling edge.
	// An edge passes first, so a strobe is never lowered and raised at once.
	task key(input int k);
		@(negedge clk);
		case (k)
			0: commit = 1'b1;
			1: cancel = 1'b1;
			2: bias_key = 1'b1;
			3: trigger = 1'b1;
			4: param_next = 1'b1;
			5: param_prev = 1'b1;
			6: edit_valid = 1'b1;
			default: wave_pick_valid = 1'b1;
		endcase
		@(negedge clk);
		{commit, cancel, bias_key, trigger} = 4'h0;
		{param_next, param_prev, edit_valid, wave_pick_valid} = 4'h0;
	endtask

	task setp(input logic [2:0] p, input logic [15:0] v);
		for (int t = 0; t < 8 && param_shown !== p; t++)
			key(4);
		edit_value = v;
		key(6);
	endtask

	task wave(input logic [2:0] w);
		wave_pick = w;
		key(7);
	endtask

	task run(input int n);
		int t;
		for (t = 0; t < n; t++)
			adq.push_back(t[10:0]);
		key(3);
		t = 1;
		while (meas_start !== 1'b1 && t < 3000) begin
			@(negedge clk);
			t++;
		end
		check({15'h0000, t >= 7 && t <= 16}, 16'h0001);
		for (t = 0; t < 3000 && sweep_active !== 1'b0; t++)
			@(negedge clk);
		@(negedge clk);
		check(bias_mv, 16'h27EC);
		check(16'(lvq.size() + adq.size()), 16'h0000);
	endtask

	// ----------------------------------------------------------------------
	// Output watcher
	// ----------------------------------------------------------------------
	always @(negedge clk) begin
		if (meas_start === 1'b1)
			check(bias_mv, lvq.size() ? lvq.pop_front() : ~bias_mv);
		if (buf_we === 1'b1)
			check({5'h00, buf_addr}, adq.size() ? {5'h00, adq.pop_front()} :
				~{5'h00, buf_addr});
	end

	// A hang stops here rather than at a simulator limit.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			n_fail++;
			results();
		end
	end

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	initial begin
		{rstn, wave_pick_valid, param_next, param_prev, edit_valid} = 5'h00;
		{commit, cancel, bias_key, trigger, fast_rate} = 5'h00;
		wave_pick = 3'h0;
		edit_value = 16'h0000;
		lat = 4'h1;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		check({5'h00, reading_total}, 16'h0001);
		check({15'h0000, bias_on}, 16'h0000);
		key(4);
		check({13'h0000, param_shown}, 16'h0002);
		key(5);
		check({13'h0000, param_shown}, 16'h0000);
		for (i = 0; i < 4; i++) begin
			rs = xs(rs);
			setp(3'h3, 16'h4E21 + rs[15:0] % 16'h2EE0);
			check({15'h0000, err_invalid}, 16'h0001);
		end
		setp(3'h3, 16'hB1DF);
		check({15'h0000, err_invalid}, 16'h0001);
		setp(3'h3, 16'hB1E0);
		check({15'h0000, err_invalid}, 16'h0000);
		setp(3'h2, 16'h0000);
		check({15'h0000, err_invalid}, 16'h0001);
		setp(3'h2, 16'hFDE8);
		check({15'h0000, err_invalid}, 16'h0000);
		setp(3'h2, 16'h0001);
		setp(3'h7, 16'h0000);
		check({15'h0000, err_invalid}, 16'h0001);
		setp(3'h6, 16'h27EF);
		key(1);
		@(negedge clk);
		check(bias_mv, 16'h0000);
		setp(3'h6, 16'h27EF);
		key(0);
		@(negedge clk);
		check(bias_mv, 16'h27EC);
		wave(3'h1);
		setp(3'h3, 16'hEC78);
		setp(3'h4, 16'h1388);
		setp(3'h5, 16'h0064);
		key(0);
		check({5'h00, reading_total}, 16'h0065);
		setp(3'h5, 16'h012C);
		key(0);
		check({5'h00, reading_total}, 16'h0023);
		setp(3'h3, 16'h1388);
		setp(3'h4, 16'hEC78);
		setp(3'h5, 16'hFF9C);
		key(0);
		check({5'h00, reading_total}, 16'h0065);
		setp(3'h5, 16'hFFFB);
		key(0);
		check({15'h0000, err_conflict}, 16'h0001);
		check({5'h00, reading_total}, 16'h01C2);
		key(2);
		check({14'h0000, bias_on, bias_ind}, 16'h0003);
		check({15'h0000, buf_clear}, 16'h0001);
		setp(3'h3, 16'h0000);
		setp(3'h4, 16'h000F);
		setp(3'h5, 16'h000A);
		key(0);
		lvq = '{16'h0000, 16'h000A, 16'h000F};
		run(3);
		wave(3'h2);
		setp(3'h4, 16'h000A);
		setp(3'h5, 16'h0005);
		key(0);
		lvq = '{16'h0000, 16'h0005, 16'h000A, 16'h0005, 16'h0000};
		run(5);
		wave(3'h1);
		setp(3'h3, 16'h000A);
		setp(3'h4, 16'h0000);
		setp(3'h5, 16'hFFFB);
		key(0);
		lvq = '{16'h000A, 16'h0005, 16'h0000};
		run(3);
		wave(3'h3);
		setp(3'h3, 16'h0000);
		setp(3'h4, 16'h000A);
		setp(3'h5, 16'h0005);
		key(0);
		lvq = '{16'h0000, 16'h0005, 16'h000A};
		run(3);
		wave(3'h5);
		check({15'h0000, err_invalid}, 16'h0001);
		wave(3'h0);
		setp(3'h3, 16'h000A);
		fast_rate = 1'b1;
		setp(3'h7, 16'h0546);
		check({15'h0000, err_invalid}, 16'h0000);
		fast_rate = 1'b0;
		setp(3'h7, 16'h0546);
		check({15'h0000, err_invalid}, 16'h0001);
		setp(3'h7, 16'h0003);
		key(0);
		check({5'h00, reading_total}, 16'h0003);
		lat = 4'h5;
		lvq = '{16'h000A, 16'h000A, 16'h000A};
		run(3);
		lvq = '{16'h000A};
		key(3);
		for (i = 0; i < 100 && meas_start !== 1'b1; i++)
			@(negedge clk);
		key(2);
		check({14'h0000, sweep_active, buf_clear}, 16'h0001);
		repeat (8) @(negedge clk);
		check(16'(lvq.size() + adq.size()), 16'h0000);
		wave(3'h4);
		key(0);
		check({15'h0000, ext_select}, 16'h0001);
		key(2);
		@(negedge clk);
		check({15'h0000, idle_msg}, 16'h0001);
		lvq = '{16'h000A, 16'h000A, 16'h000A};
		run(3);
		check({15'h0000, idle_msg}, 16'h0000);
		results();
	end
endmodule

`default_nettype wire
